// File: dv/slpcg_sva.sv
// slpcg_sva: port checks of the sleep select and gating block
// assumes: one clock, bound to slpcg_top below
module slpcg_sva (
    input wire logic                    i_ref_clk,
    input wire logic                    i_resetn,
    input wire slpcg_pkg::slpcg_req_t   i_req,
    input wire logic                    i_sleep_instr,
    input wire logic [7:0]              o_rdata,
    input wire slpcg_pkg::slpcg_sleep_t o_sleep,
    input wire slpcg_pkg::slpcg_clken_t o_clken
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // ====================
    // write cycles to each register
    sequence wr_s; i_req.wr && i_req.addr == 8'h53; endsequence
    sequence wr_a; i_req.wr && i_req.addr == 8'h64; endsequence
    sequence wr_b; i_req.wr && i_req.addr == 8'h65; endsequence
    no_go_a: assert property (!i_sleep_instr |=> !o_sleep.go)
        else $error("go without sleep");
    kind_wr_a: assert property (wr_s |=> o_sleep.kind == $past(i_req.wdata[3:1]))
        else $error("kind not written");
    kind_hold_a: assert property ($changed(o_sleep.kind) |-> $past(i_req.wr))
        else $error("kind moved alone");
    kind_dec_a: assert property (o_sleep.core_off_down == (o_sleep.kind == 3'b111)
        && o_sleep.deep_down_with_osc == (o_sleep.kind == 3'b110)) else $error("bad decode");
    serial_a: assert property (wr_a |=> o_clken.serial0 == !$past(i_req.wdata[1]))
        else $error("serial gate");
    gate_a_a: assert property (wr_a |=> o_clken.timer0 == !$past(i_req.wdata[5])
        && o_clken.two_wire == !$past(i_req.wdata[7])) else $error("gate a");
    pin_chg_a: assert property (wr_b |=> o_clken.pin_change == !$past(i_req.wdata[1]))
        else $error("pin change gate");
    gate_b_a: assert property (wr_b |=> o_clken.watchdog == !$past(i_req.wdata[5]))
        else $error("gate b");
    clk_hold_a: assert property ($changed(o_clken) |-> $past(i_req.wr))
        else $error("enable moved alone");
endmodule // slpcg_sva

bind slpcg_top slpcg_sva u_sva (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req(i_req),
    .i_sleep_instr(i_sleep_instr), .o_rdata(o_rdata), .o_sleep(o_sleep), .o_clken(o_clken));

// File: dv/tb_top.sv
// tb_top: self-checking bench of the sleep select and gating block
// assumes: slpcg_pkg and slpcg_top compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                    i_ref_clk = 0;
    logic                    i_resetn = 0;
    logic                    i_sleep_instr = 0;
    slpcg_pkg::slpcg_req_t   i_req = '0;
    logic [7:0]              o_rdata;
    slpcg_pkg::slpcg_sleep_t o_sleep;
    slpcg_pkg::slpcg_clken_t o_clken;
    int                      num_errors = 0;
    int                      comparisons = 0;
    slpcg_top DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req(i_req),
        .i_sleep_instr(i_sleep_instr), .o_rdata(o_rdata), .o_sleep(o_sleep), .o_clken(o_clken));
    // ====================
    // clock, 25 ns period
    initial forever #12.5 i_ref_clk = ~i_ref_clk;
    // expected enables from both gating registers
    function automatic logic [10:0] exp_ck(input logic [7:0] a, b);
        return ~{a[0], a[1], a[2], a[5], a[3], a[6], b[3], a[7], b[1], b[2], b[5]};
    endfunction
    task automatic cmp(input logic [10:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_ref_clk);
        i_req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_ref_clk);
        i_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge i_ref_clk);
        i_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_ref_clk);
        i_req <= '0;
        #1 cmp(o_rdata, exp);
        @(posedge i_ref_clk);
        #1 cmp(o_rdata, 8'h00);
    endtask
    task automatic slp(input logic exp);
        @(posedge i_ref_clk);
        i_sleep_instr <= 1'b1;
        @(posedge i_ref_clk);
        i_sleep_instr <= 1'b0;
        #1 cmp(o_sleep.go, exp);
        @(posedge i_ref_clk);
        #1 cmp(o_sleep.go, 1'b0);
    endtask
    // every select code, reserved upper bits written high
    task automatic t_kind;
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            wr(8'h53, {4'hF, k, 1'b1});
            #1 cmp(o_sleep[6:0], {k, k == 6, k == 3, k == 7, k[2:1] == 2'b10});
            rd(8'h53, {4'h0, k, 1'b1});
        end
        wr(8'h53, 8'h00);
        slp(1'b0);
        wr(8'h53, 8'h01);
        slp(1'b1);
        wr(8'h53, 8'h00);
    endtask
    // walking one through both gating registers
    task automatic t_gate;
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            wr(8'h64, m);
            #1 cmp(o_clken, exp_ck(m, m >> 1));
            rd(8'h64, m & 8'hEF);
            wr(8'h65, m);
            #1 cmp(o_clken, exp_ck(m, m));
            rd(8'h65, m & 8'h2E);
        end
        wr(8'h70, 8'hFF);
        #1 cmp(o_clken, exp_ck(8'h80, 8'h80));
        rd(8'h70, 8'h00);
        wr(8'h64, 8'h00);
        wr(8'h65, 8'h00);
        #1 cmp(o_clken, 11'h7FF);
    endtask
    // mid-run reset clears the first gating register again
    task automatic t_reset;
        wr(8'h64, 8'hFF);
        #1 cmp(o_clken, exp_ck(8'hFF, 8'h00));
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        #1 cmp(o_clken, 11'h7FF);
        rd(8'h64, 8'h00);
    endtask
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        #1 cmp(o_clken, 11'h7FF);
        rd(8'h53, 8'h00);
        t_kind();
        t_gate();
        t_reset();
        give_verdict();
    end
    // watchdog
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        num_errors++;
        give_verdict();
    end
endmodule // tb_top

// File: hw/slpcg_cfg.svh
// slpcg_cfg.svh: offsets, field positions, reset values of the sleep and gating block
// assumes: included by bare name wherever these constants are needed
`ifndef SLPCG_CFG_SVH
`define SLPCG_CFG_SVH

// ==========================================================================
// register offsets (byte addresses on the plain port)
`define SLPCG_OFS_SLEEP_CONTROL 8'h53
`define SLPCG_OFS_GATE_A        8'h64
`define SLPCG_OFS_GATE_B        8'h65

// ==========================================================================
// reset values and writable-bit masks
`define SLPCG_RST_SLEEP_CONTROL 8'h00
`define SLPCG_RST_GATE_A        8'h00
`define SLPCG_RST_GATE_B        8'h00
`define SLPCG_RST_RDATA         8'h00
`define SLPCG_RST_GO            1'b0
`define SLPCG_MASK_SLEEP_CONTROL 8'h0F
`define SLPCG_MASK_GATE_A       8'hEF
`define SLPCG_MASK_GATE_B       8'h2E

// ==========================================================================
// field positions
`define SLPCG_BIT_SLEEP_ALLOW   0
`define SLPCG_BIT_KIND_LO       1
`define SLPCG_BIT_KIND_HI       3
`define SLPCG_BIT_CONVERTER     0
`define SLPCG_BIT_SERIAL0       1
`define SLPCG_BIT_SYNC_PORT     2
`define SLPCG_BIT_TIMER1        3
`define SLPCG_BIT_TIMER0        5
`define SLPCG_BIT_TIMER2        6
`define SLPCG_BIT_TWO_WIRE      7
`define SLPCG_BIT_PIN_CHANGE    1
`define SLPCG_BIT_FLASH_IF      2
`define SLPCG_BIT_TIMER3        3
`define SLPCG_BIT_WATCHDOG      5

`endif

// File: hw/slpcg_pkg.sv
// slpcg_pkg: types of the sleep select and clock gating block
// assumes: constants come from slpcg_cfg.svh
package slpcg_pkg;

    // ======================================================================
    // sleep kinds, encoded as the three-bit select field
    typedef enum logic [2:0] {
        SLPCG_IDLE       = 3'b000,
        SLPCG_NOISE_RED  = 3'b001,
        SLPCG_SAVE       = 3'b010,
        SLPCG_DEEP_NOOSC = 3'b011,
        SLPCG_DEEP_OSC   = 3'b110,
        SLPCG_CORE_OFF   = 3'b111
    } slpcg_kind_t;

    // ======================================================================
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } slpcg_req_t;

    // ======================================================================
    // sleep request towards the power manager
    typedef struct packed {
        logic       go;
        logic [2:0] kind;
        logic       deep_down_with_osc;
        logic       deep_down_no_osc;
        logic       core_off_down;
        logic       reserved_kind;
    } slpcg_sleep_t;

    // ======================================================================
    // per-module clock enables, 1 = clock running
    typedef struct packed {
        logic converter;
        logic serial0;
        logic sync_port;
        logic timer0;
        logic timer1;
        logic timer2;
        logic timer3;
        logic two_wire;
        logic pin_change;
        logic flash_if;
        logic watchdog;
    } slpcg_clken_t;

endpackage

// File: hw/slpcg_top.sv
// slpcg_top: sleep control register and two module clock gating registers
// assumes: core drives the plain register port and pulses i_sleep_instr on sleep;
// each module clock is gated by an integrated latch-based cell fed from o_clken
//
// The address-and-strobe port was left to the implementer.
`include "slpcg_cfg.svh"

module slpcg_top #(
    parameter int unsigned REG_W     = 8,  // register and data bus width
    parameter int unsigned NUM_CLKEN = 11  // number of gated module clocks
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_resetn,
    input  wire slpcg_pkg::slpcg_req_t i_req,
    input  wire logic                  i_sleep_instr,
    output logic [7:0]                 o_rdata,
    output slpcg_pkg::slpcg_sleep_t    o_sleep,
    output slpcg_pkg::slpcg_clken_t    o_clken
);

    // ======================================================================
    // timing at the ports
    // a write lands at the edge that sees its strobe, so the sleep and
    // enable outputs follow right after that edge; read data stand only
    // in the cycle after the read strobe; the sleep request is a pulse
    // one cycle after the instruction

    // ======================================================================
    // elaboration checks
    // port structs, masks and field positions are fixed at these sizes;
    // other values would misalign fields silently, so refuse them
    if (REG_W != 8) begin : g_bad_reg_w
        $error("slpcg_top: REG_W must be 8");
    end

    if (NUM_CLKEN != $bits(slpcg_pkg::slpcg_clken_t)) begin : g_bad_num_clken
        $error("slpcg_top: NUM_CLKEN must match the enable struct");
    end

    if (`SLPCG_BIT_KIND_HI - `SLPCG_BIT_KIND_LO != 2) begin : g_bad_kind_field
        $error("slpcg_top: select field must be three bits wide");
    end

    // reset values must not set bits that a write could never set
    if ((`SLPCG_RST_SLEEP_CONTROL & ~`SLPCG_MASK_SLEEP_CONTROL) != 8'h00) begin : g_bad_rst_sc
        $error("slpcg_top: sleep control reset sets a reserved bit");
    end

    if ((`SLPCG_RST_GATE_A & ~`SLPCG_MASK_GATE_A) != 8'h00) begin : g_bad_rst_ga
        $error("slpcg_top: gating register a reset sets a reserved bit");
    end

    if ((`SLPCG_RST_GATE_B & ~`SLPCG_MASK_GATE_B) != 8'h00) begin : g_bad_rst_gb
        $error("slpcg_top: gating register b reset sets a reserved bit");
    end

    // ======================================================================
    // register state and next values
    logic [REG_W-1:0] sleep_control;            // allow bit and select field
    logic [REG_W-1:0] module_clock_gate_a;      // first gating register
    logic [REG_W-1:0] module_clock_gate_b;      // second gating register
    logic [REG_W-1:0] next_sleep_control;
    logic [REG_W-1:0] next_module_clock_gate_a;
    logic [REG_W-1:0] next_module_clock_gate_b;
    logic [7:0]       next_rdata;
    logic             go;                       // registered sleep request
    logic             next_go;

    // ======================================================================
    // address decode of the plain register port
    logic             hit_sleep_control;
    logic             hit_gate_a;
    logic             hit_gate_b;
    logic             wr_sleep_control;
    logic             wr_gate_a;
    logic             wr_gate_b;

    // one comparator per register
    assign hit_sleep_control = (i_req.addr == `SLPCG_OFS_SLEEP_CONTROL);
    assign hit_gate_a        = (i_req.addr == `SLPCG_OFS_GATE_A);
    assign hit_gate_b        = (i_req.addr == `SLPCG_OFS_GATE_B);

    // qualified write strobes; unmapped addresses change nothing
    assign wr_sleep_control  = i_req.wr & hit_sleep_control;
    assign wr_gate_a         = i_req.wr & hit_gate_a;
    assign wr_gate_b         = i_req.wr & hit_gate_b;

    // ======================================================================
    // sleep control register
    // reserved upper bits are masked on write and so always read zero
    always_comb begin
        next_sleep_control = sleep_control;
        if (wr_sleep_control) begin
            next_sleep_control = i_req.wdata & `SLPCG_MASK_SLEEP_CONTROL;
        end
    end

    // sleep control flops
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sleep_control <= `SLPCG_RST_SLEEP_CONTROL;
        end else begin
            sleep_control <= next_sleep_control;
        end
    end

    // ======================================================================
    // first gating register
    // reserved bit 4 is masked on write and so always reads zero
    always_comb begin
        next_module_clock_gate_a = module_clock_gate_a;
        if (wr_gate_a) begin
            next_module_clock_gate_a = i_req.wdata & `SLPCG_MASK_GATE_A;
        end
    end

    // first gating register flops
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            module_clock_gate_a <= `SLPCG_RST_GATE_A;
        end else begin
            module_clock_gate_a <= next_module_clock_gate_a;
        end
    end

    // ======================================================================
    // second gating register
    // only bits 1, 2, 3 and 5 are writable, the rest read zero
    always_comb begin
        next_module_clock_gate_b = module_clock_gate_b;
        if (wr_gate_b) begin
            next_module_clock_gate_b = i_req.wdata & `SLPCG_MASK_GATE_B;
        end
    end

    // second gating register flops
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            module_clock_gate_b <= `SLPCG_RST_GATE_B;
        end else begin
            module_clock_gate_b <= next_module_clock_gate_b;
        end
    end

    // ======================================================================
    // read data
    // zero outside the cycle after a read strobe, so data stand one cycle
    always_comb begin
        next_rdata = `SLPCG_RST_RDATA;
        if (i_req.rd) begin
            case (i_req.addr)
                `SLPCG_OFS_SLEEP_CONTROL: next_rdata = sleep_control;
                `SLPCG_OFS_GATE_A:        next_rdata = module_clock_gate_a;
                `SLPCG_OFS_GATE_B:        next_rdata = module_clock_gate_b;
                default:                  next_rdata = `SLPCG_RST_RDATA;
            endcase
        end
    end

    // read data flops
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= `SLPCG_RST_RDATA;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // ======================================================================
    // sleep request
    // the allow bit as it stood before any same-cycle write decides;
    // the request never clears the allow bit, software has to
    always_comb begin
        next_go = i_sleep_instr & sleep_control[`SLPCG_BIT_SLEEP_ALLOW];
    end

    // sleep request flop, a one-cycle pulse
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            go <= `SLPCG_RST_GO;
        end else begin
            go <= next_go;
        end
    end

    // ======================================================================
    // sleep kind decode
    // reserved codes are flagged but the request still goes out
    logic [2:0]       kind;
    logic             deep_with_osc;
    logic             deep_no_osc;
    logic             core_off;
    logic             reserved_kind;

    assign kind = sleep_control[`SLPCG_BIT_KIND_HI:`SLPCG_BIT_KIND_LO];

    // one flag per power-down kind, reserved codes by default
    always_comb begin
        deep_with_osc = 1'b0;
        deep_no_osc   = 1'b0;
        core_off      = 1'b0;
        reserved_kind = 1'b0;
        case (kind)
            slpcg_pkg::SLPCG_IDLE,
            slpcg_pkg::SLPCG_NOISE_RED,
            slpcg_pkg::SLPCG_SAVE: begin
                reserved_kind = 1'b0; // clocked kinds need no extra flag
            end
            slpcg_pkg::SLPCG_DEEP_NOOSC: begin
                deep_no_osc = 1'b1;
            end
            slpcg_pkg::SLPCG_DEEP_OSC: begin
                deep_with_osc = 1'b1;
            end
            slpcg_pkg::SLPCG_CORE_OFF: begin
                core_off = 1'b1;
            end
            default: begin
                reserved_kind = 1'b1;
            end
        endcase
    end

    // sleep request leaves as the packed struct
    always_comb begin
        o_sleep.go                 = go;
        o_sleep.kind               = kind;
        o_sleep.deep_down_with_osc = deep_with_osc;
        o_sleep.deep_down_no_osc   = deep_no_osc;
        o_sleep.core_off_down      = core_off;
        o_sleep.reserved_kind      = reserved_kind;
    end

    // ======================================================================
    // module clock enables, 1 = clock running
    logic [2*REG_W-1:0]   gate_bits; // register b above register a
    logic [NUM_CLKEN-1:0] run_vec;   // enables in struct bit order

    // gating bit behind each enable, from the struct's low end upwards
    localparam int unsigned CLKEN_SRC [NUM_CLKEN] = '{
        `SLPCG_BIT_WATCHDOG   + REG_W, // watchdog counter
        `SLPCG_BIT_FLASH_IF   + REG_W, // flash interface
        `SLPCG_BIT_PIN_CHANGE + REG_W, // pin change logic
        `SLPCG_BIT_TWO_WIRE,           // two-wire port
        `SLPCG_BIT_TIMER3     + REG_W, // timer 3
        `SLPCG_BIT_TIMER2,             // timer 2
        `SLPCG_BIT_TIMER1,             // timer 1
        `SLPCG_BIT_TIMER0,             // timer 0
        `SLPCG_BIT_SYNC_PORT,          // synchronous serial port
        `SLPCG_BIT_SERIAL0,            // serial port 0
        `SLPCG_BIT_CONVERTER           // converter controller
    };

    // writable bits of both gating registers side by side
    localparam logic [2*REG_W-1:0] GATE_MASK = {`SLPCG_MASK_GATE_B, `SLPCG_MASK_GATE_A};

    assign gate_bits = {module_clock_gate_b, module_clock_gate_a};

    // one enable per gated module; a set bit stops the edges only, the
    // module keeps its state and runs again from the next edge once cleared
    for (genvar e = 0; e < NUM_CLKEN; e++) begin : g_clken
        if (!GATE_MASK[CLKEN_SRC[e]]) begin : g_bad_src
            $error("slpcg_top: enable mapped to a reserved gating bit");
        end
        assign run_vec[e] = ~gate_bits[CLKEN_SRC[e]];
    end

    // enables leave as the packed struct, converter at the top
    assign o_clken = slpcg_pkg::slpcg_clken_t'(run_vec);

endmodule // slpcg_top
